//--- verilog/palette_bank_params.svh
// palette bank select / data window constants
// assumes a 32-bit AXI4-Lite register map, byte addresses
`ifndef PALETTE_BANK_PARAMS_SVH
`define PALETTE_BANK_PARAMS_SVH
`define PAL_IDX_ADDR        4'h5
`define PAL_IDX_BANK        4'h6
`define PAL_IDX_DATA        4'h7
`define PAL_IDX_MODE        4'h8
`define PAL_OFF_ADDR        8'h54
`define PAL_OFF_BANK        8'h58
`define PAL_OFF_DATA        8'h5c
`define PAL_OFF_MODE        8'h60
`define PAL_RESET_ADDR      6'h00
`define PAL_RESET_BANK      6'h00
`define PAL_RESET_MODE      3'h0
`define PAL_RESP_OKAY       2'h0
`define PAL_RESP_SLVERR     2'h2
`endif

//--- verilog/palette_bank_pkg.sv
// types for the palette access block
// assumes palette_bank_params.svh constants alongside
package palette_bank_pkg;
  typedef enum logic [1:0] {
    SEL_AUTO  = 2'b00,
    SEL_RED   = 2'b01,
    SEL_GREEN = 2'b10,
    SEL_BLUE  = 2'b11
  } table_select_type;
  typedef enum logic [1:0] {
    DEPTH_1BPP = 2'b00,
    DEPTH_2BPP = 2'b01,
    DEPTH_4BPP = 2'b10
  } depth_type;
  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } color_type;
  typedef struct packed {
    logic [1:0] red;
    logic [1:0] green;
    logic [1:0] blue;
  } bank_type;
endpackage

//--- verilog/palette_bank_select_access.sv
// palette tables with bank select, address pointer and data window on AXI4-Lite
// assumes one clock; pixel pipeline presents pixel value and takes colour a cycle later
//
// Behaviour
// - in 2 bpp colour, red bank field picks one of four 4-entry red banks
// - in 2 bpp colour or gray, green bank field picks green bank of four
// - in 2 bpp colour, blue bank field picks one of four 4-entry blue banks
// - at 4 bpp bank fields ignored, pixel indexes full 16 entries
// - one data register is read/write window into the three tables
// - window carries 4-bit value in bits 3..0, upper bits unused
// - window entry is the one chosen by the address register
// - each cycle with a window read or byte-lane-0 window write advances pointer once, unless address written; interleaved order red, green, blue
// - select field: 00 interleaved, 01 red, 10 green/gray, 11 blue
// - in interleaved mode, address write points at red of written index
`timescale 1ns/100ps
`include "palette_bank_params.svh"
module palette_bank_select_access
  import palette_bank_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  pixelValue,
  output color_type        pixelColor
);
  logic [3:0]       redTable   [16];
  logic [3:0]       greenTable [16];
  logic [3:0]       blueTable  [16];
  logic [5:0]       addrReg_q, addrReg_d;
  logic [1:0]       phase_q, phase_d;
  logic [5:0]       bankReg_q, bankReg_d;
  logic [2:0]       modeReg_q, modeReg_d;
  logic             awHeld_q, awHeld_d;
  logic [7:0]       awAddr_q, awAddr_d;
  logic             wHeld_q, wHeld_d;
  logic [31:0]      wData_q, wData_d;
  logic [3:0]       wStrb_q, wStrb_d;
  logic             bValid_q, bValid_d;
  logic [1:0]       bResp_q, bResp_d;
  logic             rValid_q, rValid_d;
  logic [31:0]      rData_q, rData_d;
  logic [1:0]       rResp_q, rResp_d;
  color_type        pixelColor_q, pixelColor_d;
  logic             doWrite, doRead, winWrite, winAccess;
  logic [1:0]       curSel;
  logic [1:0]       curTable;
  logic [3:0]       curIndex;
  bank_type         banks;
  depth_type        depth;
  logic             grayMode;

  // map a pixel value into a table index through a bank field
  function automatic logic [3:0] bankIndex(input depth_type d, input logic [1:0] bank, input logic [3:0] pix);
    case (d)
      DEPTH_1BPP: bankIndex = {1'b0, bank, pix[0]};
      DEPTH_2BPP: bankIndex = {bank, pix[1:0]};
      default:    bankIndex = pix;
    endcase
  endfunction

  assign curSel   = addrReg_q[5:4];
  assign curIndex = addrReg_q[3:0];
  assign banks    = bankReg_q;
  assign depth    = depth_type'(modeReg_q[1:0]);
  assign grayMode = modeReg_q[2];
  // table that the window currently reaches
  assign curTable = (curSel == SEL_AUTO) ? phase_q : curSel;

  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready  = !wHeld_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
  assign pixelColor    = pixelColor_q;

  assign doWrite   = awHeld_q && wHeld_q && !bValid_q;
  assign doRead    = s_axi_arvalid && !rValid_q;
  assign winWrite  = doWrite && awAddr_q == `PAL_OFF_DATA && wStrb_q[0];
  assign winAccess = winWrite || (doRead && s_axi_araddr == `PAL_OFF_DATA);

  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d  = wHeld_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    addrReg_d = addrReg_q;
    phase_d   = phase_q;
    bankReg_d = bankReg_q;
    modeReg_d = modeReg_q;
    if (s_axi_awvalid && !awHeld_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_q) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = `PAL_RESP_OKAY;
      case (awAddr_q)
        `PAL_OFF_ADDR: begin
          if (wStrb_q[0]) begin
            addrReg_d = wData_q[5:0];
            phase_d   = SEL_RED;
          end
        end
        `PAL_OFF_BANK: begin
          if (wStrb_q[0]) bankReg_d = wData_q[5:0];
        end
        `PAL_OFF_DATA: begin
        end
        `PAL_OFF_MODE: begin
          if (wStrb_q[0]) modeReg_d = wData_q[2:0];
        end
        default: bResp_d = `PAL_RESP_SLVERR;
      endcase
    end
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
    if (doRead) begin
      rValid_d = 1'b1;
      rResp_d  = `PAL_RESP_OKAY;
      case (s_axi_araddr)
        `PAL_OFF_ADDR: rData_d = {26'h0, addrReg_q};
        `PAL_OFF_BANK: rData_d = {26'h0, bankReg_q};
        `PAL_OFF_MODE: rData_d = {29'h0, modeReg_q};
        `PAL_OFF_DATA: begin
          case (curTable)
            SEL_RED:  rData_d = {28'h0, redTable[curIndex]};
            SEL_BLUE: rData_d = {28'h0, blueTable[curIndex]};
            default:  rData_d = {28'h0, greenTable[curIndex]};
          endcase
        end
        default: begin
          rData_d = 32'h0;
          rResp_d = `PAL_RESP_SLVERR;
        end
      endcase
    end
    // pointer advance; an address write in the same cycle wins
    if (winAccess && !(doWrite && awAddr_q == `PAL_OFF_ADDR)) begin
      if (curSel == SEL_AUTO) begin
        if (phase_q == SEL_BLUE) begin
          phase_d   = SEL_RED;
          addrReg_d = {curSel, curIndex + 4'h1};
        end else begin
          phase_d = phase_q + 2'h1;
        end
      end else begin
        addrReg_d = {curSel, curIndex + 4'h1};
      end
    end
  end

  always_comb begin
    pixelColor_d.red   = redTable[bankIndex(depth, banks.red, pixelValue)];
    pixelColor_d.green = greenTable[bankIndex(depth, banks.green, pixelValue)];
    pixelColor_d.blue  = blueTable[bankIndex(depth, banks.blue, pixelValue)];
    if (grayMode) begin
      pixelColor_d.red  = pixelColor_d.green;
      pixelColor_d.blue = pixelColor_d.green;
    end
  end

  always_ff @(posedge clock) begin
    if (winWrite) begin
      case (curTable)
        SEL_RED:  redTable[curIndex]   <= wData_q[3:0];
        SEL_BLUE: blueTable[curIndex]  <= wData_q[3:0];
        default:  greenTable[curIndex] <= wData_q[3:0];
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld_q  <= 1'b0;
      awAddr_q  <= 8'h00;
      wHeld_q   <= 1'b0;
      wData_q   <= 32'h0;
      wStrb_q   <= 4'h0;
      bValid_q  <= 1'b0;
      bResp_q   <= `PAL_RESP_OKAY;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0;
      rResp_q   <= `PAL_RESP_OKAY;
      addrReg_q <= `PAL_RESET_ADDR;
      phase_q   <= SEL_RED;
      bankReg_q <= `PAL_RESET_BANK;
      modeReg_q <= `PAL_RESET_MODE;
      pixelColor_q <= '0;
    end else begin
      awHeld_q  <= awHeld_d;
      awAddr_q  <= awAddr_d;
      wHeld_q   <= wHeld_d;
      wData_q   <= wData_d;
      wStrb_q   <= wStrb_d;
      bValid_q  <= bValid_d;
      bResp_q   <= bResp_d;
      rValid_q  <= rValid_d;
      rData_q   <= rData_d;
      rResp_q   <= rResp_d;
      addrReg_q <= addrReg_d;
      phase_q   <= phase_d;
      bankReg_q <= bankReg_d;
      modeReg_q <= modeReg_d;
      pixelColor_q <= pixelColor_d;
    end
  end
endmodule

//--- sim/palette_bank_monitor.sv
// bus-side assertions for the palette access block
// assumes binding onto palette_bank_select_access
`timescale 1ns/100ps
module palette_bank_monitor (
  input logic        clock,
  input logic        rst,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [1:0]  s_axi_rresp,
  input logic [31:0] s_axi_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wrTaken |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  AST_WR_HOLD: assert property (wrTaken |=> !s_axi_awready && !s_axi_wready) else $error("write not held");
  AST_RD_ANSWER: assert property (rdTaken |-> ##[1:2] s_axi_rvalid) else $error("no read answer");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken twice");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  AST_ERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read data");
endmodule
bind palette_bank_select_access palette_bank_monitor mon (.*);

//--- sim/testbench.sv
// self-checking bench for the palette access block
// assumes design files and monitor compiled first
`timescale 1ns/100ps
`include "palette_bank_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module testbench;
  import palette_bank_pkg::*;
  logic        clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, data;
  logic [3:0]  s_axi_wstrb = 4'hf, pixelValue = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  color_type   pixelColor;
  logic [3:0]  tbl [3][16];
  int          n_errors = 0, total_checks = 0;
  always #25 clock = ~clock;
  palette_bank_select_access dut (.*);
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = 2'h0);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    data = s_axi_rdata;
    s_axi_rready <= 0;
    `CHK(s_axi_rresp, er)
  endtask
  function automatic logic [3:0] ix(input logic [3:0] p, input logic [2:0] m, input logic [1:0] k);
    return m[1] ? p : m[0] ? {k, p[1:0]} : {1'b0, k, p[0]};
  endfunction
  function automatic color_type expc(input logic [3:0] p, input logic [2:0] m, input bank_type b);
    color_type c;
    c.red = tbl[0][ix(p, m, b.red)];
    c.green = tbl[1][ix(p, m, b.green)];
    c.blue = tbl[2][ix(p, m, b.blue)];
    if (m[2]) c = {3{c.green}};
    return c;
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end
  initial begin
    logic [3:0] v;
    logic [2:0] m;
    bank_type   b;
    void'($urandom(32'hadf9e0df));
    repeat (20) @(posedge clock);
    rst <= 0;
    wr(`PAL_OFF_ADDR, 32'h0);
    for (int i = 0; i < 48; i++) begin
      v = 4'($urandom);
      tbl[i % 3][i / 3] = v;
      wr(`PAL_OFF_DATA, {28'($urandom), v});
    end
    wr(`PAL_OFF_ADDR, 32'h0);
    for (int i = 0; i < 48; i++) begin
      rd(`PAL_OFF_DATA);
      `CHK(data, {28'h0, tbl[i % 3][i / 3]})
    end
    $display("interleaved test done");
    for (int k = 1; k < 4; k++) begin
      wr(`PAL_OFF_ADDR, {26'h0, 2'(k), 4'hf});
      for (int i = 0; i < 2; i++) begin
        v = 4'($urandom);
        tbl[k - 1][(15 + i) % 16] = v;
        wr(`PAL_OFF_DATA, {28'h0, v});
      end
      wr(`PAL_OFF_ADDR, {26'h0, 2'(k), 4'hf});
      for (int i = 0; i < 2; i++) begin
        rd(`PAL_OFF_DATA);
        `CHK(data, {28'h0, tbl[k - 1][(15 + i) % 16]})
      end
      rd(`PAL_OFF_ADDR);
      `CHK(data, {26'h0, 2'(k), 4'h1})
    end
    $display("single table test done");
    repeat (40) begin
      m = {1'($urandom), 2'($urandom % 3)};
      b = 6'($urandom);
      wr(`PAL_OFF_MODE, {29'h0, m});
      wr(`PAL_OFF_BANK, {26'h0, b});
      rd(`PAL_OFF_BANK);
      `CHK(data, {26'h0, b})
      rd(`PAL_OFF_MODE);
      `CHK(data, {29'h0, m})
      repeat (4) begin
        v = 4'($urandom);
        @(posedge clock);
        pixelValue <= v;
        @(posedge clock);
        #1 `CHK(pixelColor, expc(v, m, b))
      end
    end
    $display("bank select test done");
    // write with byte lane 0 off must leave the bank fields alone
    s_axi_wstrb <= 4'he;
    wr(`PAL_OFF_BANK, {26'h0, ~6'(b)});
    s_axi_wstrb <= 4'hf;
    rd(`PAL_OFF_BANK);
    `CHK(data, {26'h0, b})
    $display("byte strobe test done");
    rd(8'h00, `PAL_RESP_SLVERR);
    `CHK(data, 32'h0)
    wr(8'h04, 32'h1, `PAL_RESP_SLVERR);
    $display("unmapped test done");
    complete_run();
  end
endmodule
